// >>> panel_vertical_scroll.sv
// Vertical scroll window control and display line remapping
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "scroll_consts.svh"
//
// Contract
// - Scrolling is set by a window top line, a window line count and a shift amount.
// - In partial display mode no scroll offset is applied at all.
// - The window top field is 9 bits holding the Y address, 000h to 13Fh.
// - The window height field is 9 bits holding line count minus one.
// - The shift field is 9 bits holding the shift directly, zero meaning no scroll.
// - A top plus height code of 320 or more makes the setting invalid, no scroll.
// - A shift larger than the height code makes the setting invalid, no scroll.
// - Writing a zero shift stops scrolling at once, in any order.
// - Shift writes are ignored while partial display mode is on.
// - The reset command clears all three fields; the reset pin leaves them alone.
module panel_vertical_scroll (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic pin_reset_n_in,
  input wire logic reset_cmd_in,
  input wire logic [6:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  input wire logic partial_mode_in,
  input wire logic frame_start_in,
  input wire logic line_req_in,
  input wire logic [8:0] line_in,
  output logic [8:0] fetch_line_out,
  output logic fetch_valid_out,
  output logic scroll_active_out
);
  scroll_pkg::scroll_state_type cur;
  scroll_pkg::scroll_state_type next_cur;
  logic [8:0] mapped_line;
  logic [9:0] bound_sum;
  logic settings_ok;
  logic pin_reset;
  logic [9:0] ref_sum;
  logic [9:0] ref_line;
  // Sync flops rest at the pin's idle level so reset release makes no pin pulse
  localparam scroll_pkg::scroll_state_type reset_state = '{
    pin_sync1: 1'b1,
    pin_sync2: 1'b1,
    default: '0
  };

  scroll_line_map scroll_line_map_inst (
    .line_in(line_in),
    .top_in(cur.act_top),
    .height_in(cur.act_height),
    .step_in(cur.act_step),
    .enable_in(cur.act_on && !partial_mode_in),
    .ram_line_out(mapped_line)
  );

  always_comb begin
    next_cur = cur;
    pin_reset = !cur.pin_sync2;
    bound_sum = {1'b0, cur.top} + {1'b0, cur.height};
    settings_ok = (bound_sum < `SCR_PANEL_LINES)
      && (cur.step <= cur.height)
      && (cur.step != `SCR_STEP_OFF)
      && !partial_mode_in;
    if (ce_in) begin
      next_cur.pin_sync1 = pin_reset_n_in;
      next_cur.pin_sync2 = cur.pin_sync1;
      next_cur.rd_data = '0;
      next_cur.fetch_valid = 1'b0;
      if (rd_in) begin
        case (addr_in)
          `SCR_OFF_TOP: next_cur.rd_data = {7'h00, cur.top};
          `SCR_OFF_HEIGHT: next_cur.rd_data = {7'h00, cur.height};
          `SCR_OFF_STEP: next_cur.rd_data = {7'h00, cur.step};
          `SCR_OFF_STATUS: next_cur.rd_data = {15'h0000, cur.act_on};
          default: next_cur.rd_data = '0;
        endcase
      end
      // Settings move to the active set only at a frame start
      if (frame_start_in) begin
        next_cur.act_top = cur.top;
        next_cur.act_height = cur.height;
        next_cur.act_step = cur.step;
        next_cur.act_on = settings_ok;
      end
      if (wr_in) begin
        case (addr_in)
          `SCR_OFF_TOP: next_cur.top = wr_data_in[8:0];
          `SCR_OFF_HEIGHT: next_cur.height = wr_data_in[8:0];
          `SCR_OFF_STEP: begin
            if (!partial_mode_in) begin
              next_cur.step = wr_data_in[8:0];
              if (wr_data_in[8:0] == `SCR_STEP_OFF) begin
                next_cur.act_on = 1'b0;
              end
            end
          end
          default: next_cur.step = next_cur.step;
        endcase
      end
      if (line_req_in) begin
        next_cur.fetch_line = mapped_line;
        next_cur.fetch_valid = 1'b1;
      end
      // Reset pin restarts the timing side only
      if (pin_reset) begin
        next_cur.act_on = 1'b0;
        next_cur.fetch_valid = 1'b0;
      end
      if (reset_cmd_in) begin
        next_cur.top = `SCR_REG_RESET;
        next_cur.height = `SCR_REG_RESET;
        next_cur.step = `SCR_REG_RESET;
        next_cur.act_on = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cur <= reset_state;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data_out = cur.rd_data;
  assign fetch_line_out = cur.fetch_line;
  assign fetch_valid_out = cur.fetch_valid;
  assign scroll_active_out = cur.act_on;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  chk_partial_no_shift: assert property (
    ce_in && line_req_in && partial_mode_in |=> fetch_line_out == $past(line_in))
    else $error("line remapped during partial mode");
  chk_bound_invalid: assert property (
    ce_in && frame_start_in && ({1'b0, cur.top} + {1'b0, cur.height} >= `SCR_PANEL_LINES)
    |=> !scroll_active_out)
    else $error("scroll active with window past last line");
  chk_step_invalid: assert property (
    ce_in && frame_start_in && (cur.step > cur.height) |=> !scroll_active_out)
    else $error("scroll active with shift above height");
  chk_stop_write: assert property (
    ce_in && wr_in && addr_in == `SCR_OFF_STEP && wr_data_in[8:0] == `SCR_STEP_OFF
    && !partial_mode_in |=> !scroll_active_out)
    else $error("scroll not stopped by zero shift");
  chk_partial_ignore: assert property (
    ce_in && wr_in && addr_in == `SCR_OFF_STEP && partial_mode_in && !reset_cmd_in
    |=> cur.step == $past(cur.step))
    else $error("shift written in partial mode");
  chk_cmd_clear: assert property (
    ce_in && reset_cmd_in |=> cur.top == '0 && cur.height == '0 && cur.step == '0)
    else $error("reset command left settings");
  chk_frame_hold: assert property (
    !(ce_in && frame_start_in) |=> $stable(cur.act_top) && $stable(cur.act_step))
    else $error("active settings changed mid frame");
  chk_outside_line: assert property (
    ce_in && line_req_in && !pin_reset && line_in < cur.act_top |=> fetch_valid_out
    && fetch_line_out == $past(line_in))
    else $error("line above window remapped");
  chk_valid_pulse: assert property (
    ce_in && !line_req_in |=> !fetch_valid_out)
    else $error("fetch valid without request");

  // Reference remap in absolute line terms, kept apart from the line mapper
  always_comb begin
    ref_sum = {1'b0, line_in} + {1'b0, cur.act_step};
    if (ref_sum > {1'b0, cur.act_top} + {1'b0, cur.act_height}) begin
      ref_line = ref_sum - {1'b0, cur.act_height} - 10'h001;
    end else begin
      ref_line = ref_sum;
    end
  end

  chk_window_map: assert property (
    ce_in && line_req_in && cur.act_on && !partial_mode_in && line_in >= cur.act_top
    && ({1'b0, line_in} <= {1'b0, cur.act_top} + {1'b0, cur.act_height})
    |=> fetch_line_out == $past(ref_line[8:0]))
    else $error("window line mapped to wrong RAM line");
  chk_valid_after_req: assert property (
    ce_in && line_req_in && !pin_reset |=> fetch_valid_out)
    else $error("line request gave no fetch valid");
  // Register side, reset paths, frame loading and clock enable freeze
  chk_pin_clear: assert property (
    ce_in && pin_reset |=> !scroll_active_out && !fetch_valid_out)
    else $error("reset pin left scrolling active");
  chk_pin_keep: assert property (
    ce_in && pin_reset && !reset_cmd_in && !wr_in
    |=> $stable(cur.top) && $stable(cur.height) && $stable(cur.step))
    else $error("reset pin changed scroll settings");
  chk_top_write: assert property (
    ce_in && wr_in && addr_in == `SCR_OFF_TOP && !reset_cmd_in
    |=> cur.top == $past(wr_data_in[8:0]))
    else $error("window top write lost");
  chk_height_write: assert property (
    ce_in && wr_in && addr_in == `SCR_OFF_HEIGHT && !reset_cmd_in
    |=> cur.height == $past(wr_data_in[8:0]))
    else $error("window height write lost");
  chk_read_step: assert property (
    ce_in && rd_in && addr_in == `SCR_OFF_STEP
    |=> rd_data_out == {7'h00, $past(cur.step)})
    else $error("shift read back wrong");
  chk_read_idle: assert property (
    ce_in && !rd_in |=> rd_data_out == 16'h0000)
    else $error("read data outside its cycle");
  chk_zero_inactive: assert property (
    ce_in && frame_start_in && cur.step == `SCR_STEP_OFF |=> !scroll_active_out)
    else $error("zero shift left scrolling active");
  chk_frame_load: assert property (
    ce_in && frame_start_in
    |=> cur.act_top == $past(cur.top) && cur.act_height == $past(cur.height))
    else $error("frame start did not load settings");
  chk_enable_freeze: assert property (
    !ce_in |=> $stable(cur))
    else $error("state moved with clock enable low");
endmodule

// >>> panel_vertical_scroll_bench.sv
// Self-checking bench for the vertical panel scroll block
`timescale 1ns/100ps
`include "scroll_consts.svh"
module panel_vertical_scroll_bench;
  logic ref_clk_in = 0, reset_in = 1, pin_reset_n = 1, rcmd = 0, wr = 0, rd = 0;
  logic part = 0, fs = 0, req = 0, fv, act, ce = 1;
  logic [6:0] addr = 0;
  logic [15:0] wd = 0, rdd;
  logic [8:0] ln = 0, fl;
  int errors = 0, check_count = 0;
  panel_vertical_scroll panel_vertical_scroll_inst (.ref_clk_in(ref_clk_in),
    .reset_in(reset_in), .ce_in(ce), .pin_reset_n_in(pin_reset_n), .reset_cmd_in(rcmd),
    .addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_data_out(rdd),
    .partial_mode_in(part), .frame_start_in(fs), .line_req_in(req), .line_in(ln),
    .fetch_line_out(fl), .fetch_valid_out(fv), .scroll_active_out(act));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [6:0] a, input logic [8:0] d);
    @(posedge ref_clk_in) begin addr <= a; wd <= {7'h00, d}; wr <= 1; end
    @(posedge ref_clk_in) wr <= 0;
  endtask
  task rd_reg(input logic [6:0] a, input logic [15:0] e);
    @(posedge ref_clk_in) begin addr <= a; rd <= 1; end
    @(posedge ref_clk_in) rd <= 0;
    #1 chk(rdd, e);
  endtask
  task map(input logic [8:0] l, input logic [8:0] e);
    @(posedge ref_clk_in) begin ln <= l; req <= 1; end
    @(posedge ref_clk_in) req <= 0;
    #1 chk({7'h00, fv, fl}, {7'h00, 1'b1, e});
  endtask
  task frame(input logic e);
    @(posedge ref_clk_in) fs <= 1;
    @(posedge ref_clk_in) fs <= 0;
    #1 chk({15'h0000, act}, {15'h0000, e});
  endtask
  task t_reset();
    rd_reg(`SCR_OFF_TOP, 16'h0000);
    rd_reg(`SCR_OFF_HEIGHT, 16'h0000);
    rd_reg(`SCR_OFF_STEP, 16'h0000);
    rd_reg(7'h20, 16'h0000);
  endtask
  task t_window();
    wr_reg(`SCR_OFF_TOP, 9'h03c);
    wr_reg(`SCR_OFF_HEIGHT, 9'h077);
    wr_reg(`SCR_OFF_STEP, 9'h001);
    rd_reg(`SCR_OFF_TOP, 16'h003c);
    map(9'h03c, 9'h03c);
    frame(1'b1);
    map(9'h03c, 9'h03d);
    map(9'h0b3, 9'h03c);
    map(9'h010, 9'h010);
    rd_reg(`SCR_OFF_STATUS, 16'h0001);
    wr_reg(`SCR_OFF_STEP, 9'h076);
    map(9'h03c, 9'h03d);
    frame(1'b1);
    map(9'h03c, 9'h0b2);
  endtask
  task t_invalid();
    wr_reg(`SCR_OFF_TOP, 9'h0ca);
    wr_reg(`SCR_OFF_HEIGHT, 9'h076);
    frame(1'b0);
    wr_reg(`SCR_OFF_TOP, 9'h0c9);
    frame(1'b1);
    wr_reg(`SCR_OFF_TOP, 9'h000);
    wr_reg(`SCR_OFF_HEIGHT, 9'h03f);
    frame(1'b0);
    wr_reg(`SCR_OFF_STEP, 9'h03f);
    frame(1'b1);
    map(9'h000, 9'h03f);
  endtask
  task t_partial();
    @(posedge ref_clk_in) part <= 1;
    map(9'h000, 9'h000);
    wr_reg(`SCR_OFF_STEP, 9'h005);
    rd_reg(`SCR_OFF_STEP, 16'h003f);
    @(posedge ref_clk_in) part <= 0;
    wr_reg(`SCR_OFF_STEP, 9'h000);
    map(9'h000, 9'h000);
  endtask
  task t_resets();
    wr_reg(`SCR_OFF_STEP, 9'h002);
    frame(1'b1);
    // Clock enable low freezes the zero-shift write and the active flag
    @(posedge ref_clk_in) ce <= 0;
    wr_reg(`SCR_OFF_STEP, 9'h000);
    @(posedge ref_clk_in) ce <= 1;
    rd_reg(`SCR_OFF_STEP, 16'h0002);
    chk({15'h0000, act}, 16'h0001);
    @(posedge ref_clk_in) pin_reset_n <= 0;
    repeat (4) @(posedge ref_clk_in);
    pin_reset_n <= 1;
    repeat (3) @(posedge ref_clk_in);
    rd_reg(`SCR_OFF_STEP, 16'h0002);
    chk({15'h0000, act}, 16'h0000);
    @(posedge ref_clk_in) rcmd <= 1;
    @(posedge ref_clk_in) rcmd <= 0;
    rd_reg(`SCR_OFF_STEP, 16'h0000);
    rd_reg(`SCR_OFF_HEIGHT, 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 0;
    t_reset();
    t_window();
    t_invalid();
    t_partial();
    t_resets();
    give_verdict();
  end
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
endmodule

// >>> scroll_consts.svh
// Constants for the vertical panel scroll block
`ifndef SCROLL_CONSTS_SVH
`define SCROLL_CONSTS_SVH
`define SCR_LINE_W 9
`define SCR_ADDR_W 7
`define SCR_DATA_W 16
`define SCR_OFF_TOP 7'h0e
`define SCR_OFF_HEIGHT 7'h0f
`define SCR_OFF_STEP 7'h10
`define SCR_OFF_STATUS 7'h11
`define SCR_PANEL_LINES 10'h140
`define SCR_REG_RESET 9'h000
`define SCR_STEP_OFF 9'h000
`endif

// >>> scroll_line_map.sv
// Maps a display line to the RAM line inside a rotating scroll window
`timescale 1ns/100ps
`include "scroll_consts.svh"
module scroll_line_map (
  input wire logic [8:0] line_in,
  input wire logic [8:0] top_in,
  input wire logic [8:0] height_in,
  input wire logic [8:0] step_in,
  input wire logic enable_in,
  output logic [8:0] ram_line_out
);
  logic [9:0] region_end;
  logic [9:0] count;
  logic [9:0] offs;
  logic [9:0] wrapped;
  logic in_region;

  always_comb begin
    region_end = {1'b0, top_in} + {1'b0, height_in};
    count = {1'b0, height_in} + 10'h001;
    in_region = (line_in >= top_in) && ({1'b0, line_in} <= region_end);
    offs = {1'b0, line_in} - {1'b0, top_in} + {1'b0, step_in};
    // Step never exceeds the height code, so one subtraction is a full modulo
    wrapped = (offs >= count) ? offs - count : offs;
    if (enable_in && in_region) begin
      ram_line_out = 9'(({1'b0, top_in} + wrapped));
    end else begin
      ram_line_out = line_in;
    end
  end
endmodule

// >>> scroll_pkg.sv
// Types shared by the vertical panel scroll block
package scroll_pkg;
  typedef logic [8:0] line_type;
  typedef struct packed {
    logic pin_sync1;
    logic pin_sync2;
    line_type top;
    line_type height;
    line_type step;
    line_type act_top;
    line_type act_height;
    line_type act_step;
    logic act_on;
    logic [15:0] rd_data;
    line_type fetch_line;
    logic fetch_valid;
  } scroll_state_type;
endpackage
